// *** srst_pkg.sv ***
`default_nettype none
package srst_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int CPU_HOLD_TIME_NS = 1000000; // 1 mS
  localparam int CPU_HOLD_CYCLES_DEF =
    (CPU_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser depth and hard/core release window in clocks
  localparam int RESET_SYNC_STAGES = 2;
  localparam int HARD_RELEASE_MIN_CLK = 4;
  localparam int HARD_RELEASE_MAX_CLK = 6;
  localparam int HARD_WAIT_CYCLES = HARD_RELEASE_MIN_CLK - RESET_SYNC_STAGES;

  // hold lengths of configuration-requested hard reset and re-init drive
  localparam int CFG_HARD_HOLD_CYCLES = 16;
  localparam int BUS_REINIT_DRIVE_CYCLES = 4;

  // structural defaults
  localparam int NUM_CPU_BUS_DEF = 2;
  localparam int NUM_PORTS_DEF = 4;

  // hard reset sequencer states
  typedef enum logic [1:0] {
    SRST_HARD_ASSERT = 2'b00,
    SRST_HARD_WAIT = 2'b01,
    SRST_HARD_RUN = 2'b10
  } srst_hard_state_t;

  // which reset classes are active
  typedef struct packed {
    logic power_good;
    logic hard;
    logic cpu_only;
    logic targeted;
    logic bus_reinit;
  } srst_status_t;

  localparam srst_status_t STATUS_RESET = 5'h18; // power-good and hard

endpackage
`default_nettype wire

// *** srst_sync.sv ***
`default_nettype none
// reset synchroniser: asserts at once, releases after STAGES edges
module srst_sync #(
  parameter int STAGES = srst_pkg::RESET_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);

  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  ////////////////////////////////////////////////////////////////////////
  // shift ones in; only the last stage is read outside
  always_comb begin
    next_chain = {chain[STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  assign rst_n = chain[STAGES-1];

endmodule
`default_nettype wire

// *** srst_system_reset_controller.sv ***
`default_nettype none
// platform reset root: classes, sequencing and propagation
module srst_system_reset_controller #(
  parameter int NUM_CPU_BUS = srst_pkg::NUM_CPU_BUS_DEF,
  parameter int NUM_PORTS = srst_pkg::NUM_PORTS_DEF,
  parameter int CPU_HOLD_CYCLES = srst_pkg::CPU_HOLD_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PLATFORM_POWER_GOOD_IN,
  input wire logic SYSTEM_HARD_RESET_IN_N,
  input wire logic CFG_HARD_RESET_REQ,
  input wire logic CFG_CPU_RESET_REQ,
  input wire logic [NUM_PORTS-1:0] CFG_PORT_RESET,
  input wire logic BUS_REINIT_N_IN,
  input wire logic INTERNAL_BUS_HANG,
  output logic [NUM_CPU_BUS-1:0] CPU_BUS_RESET_OUT_N,
  output logic HARD_RESET_N,
  output logic CORE_RESET_N,
  output logic STICKY_RESET_N,
  output logic [NUM_PORTS-1:0] PCIE_PORT_RESET_N,
  output logic [NUM_PORTS-1:0] PCIE_TRAIN_EN,
  output logic BUS_REINIT_N_OUT,
  output logic BUS_REINIT_N_OE,
  output logic IN_ORDER_QUEUE_CLEAR,
  output srst_pkg::srst_status_t RESET_STATUS
);

  localparam int CW = $clog2(CPU_HOLD_CYCLES + 1);
  localparam logic [CW-1:0] CPU_LAST = CW'(CPU_HOLD_CYCLES - 1);
  localparam logic [1:0] HW_LAST = 2'(srst_pkg::HARD_WAIT_CYCLES - 1);
  localparam logic [4:0] CFG_LOAD = 5'(srst_pkg::CFG_HARD_HOLD_CYCLES);
  localparam logic [2:0] DRV_LOAD = 3'(srst_pkg::BUS_REINIT_DRIVE_CYCLES);

  logic pg_arst_n;
  logic hard_arst_n;
  logic pg_rst_n;
  logic system_hard_reset_in_n_sync_n;
  logic hard_req;

  ////////////////////////////////////////////////////////////////////////
  // reset synchronisers
  // power-good combined asynchronously
  assign pg_arst_n = RESETN & PLATFORM_POWER_GOOD_IN;
  // reset input counts only under power good
  assign hard_arst_n = pg_arst_n & SYSTEM_HARD_RESET_IN_N;

  srst_sync #(.STAGES(srst_pkg::RESET_SYNC_STAGES)) u_pg_sync (
    .clk(CLK),
    .arst_n(pg_arst_n),
    .rst_n(pg_rst_n)
  );

  srst_sync #(.STAGES(srst_pkg::RESET_SYNC_STAGES)) u_hard_sync (
    .clk(CLK),
    .arst_n(hard_arst_n),
    .rst_n(system_hard_reset_in_n_sync_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // hard reset sequencer, power-good domain
  srst_pkg::srst_hard_state_t state;
  srst_pkg::srst_hard_state_t next_state;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [4:0] cfg_cnt;
  logic [4:0] next_cfg_cnt;

  assign hard_req = ~system_hard_reset_in_n_sync_n | (cfg_cnt != 5'h00);

  // next state and release counting
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_cfg_cnt = cfg_cnt;
    if (CFG_HARD_RESET_REQ && state == srst_pkg::SRST_HARD_RUN) begin
      next_cfg_cnt = CFG_LOAD; // config-write hard reset
    end else if (cfg_cnt != 5'h00) begin
      next_cfg_cnt = cfg_cnt - 5'h01;
    end
    unique case (state)
      srst_pkg::SRST_HARD_ASSERT: begin
        next_wait_cnt = 2'h0;
        if (!hard_req) begin
          next_state = srst_pkg::SRST_HARD_WAIT;
        end
      end
      srst_pkg::SRST_HARD_WAIT: begin
        if (hard_req) begin
          next_state = srst_pkg::SRST_HARD_ASSERT;
        end else if (wait_cnt == HW_LAST) begin
          next_state = srst_pkg::SRST_HARD_RUN;
        end else begin
          next_wait_cnt = wait_cnt + 2'h1;
        end
      end
      srst_pkg::SRST_HARD_RUN: begin
        if (hard_req) begin
          next_state = srst_pkg::SRST_HARD_ASSERT;
        end
      end
      default: begin
        next_state = srst_pkg::SRST_HARD_ASSERT;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge pg_rst_n) begin
    if (!pg_rst_n) begin
      state <= srst_pkg::SRST_HARD_ASSERT;
      wait_cnt <= 2'h0;
      cfg_cnt <= 5'h00;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      cfg_cnt <= next_cfg_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal reset outputs
  logic next_hard_n;

  assign next_hard_n = (next_state == srst_pkg::SRST_HARD_RUN);

  // hard and core only, sticky kept
  always_ff @(posedge CLK or negedge system_hard_reset_in_n_sync_n) begin
    if (!system_hard_reset_in_n_sync_n) begin
      HARD_RESET_N <= 1'b0;
      CORE_RESET_N <= 1'b0;
    end else begin
      HARD_RESET_N <= next_hard_n;
      CORE_RESET_N <= next_hard_n;
    end
  end

  always_ff @(posedge CLK or negedge pg_rst_n) begin
    if (!pg_rst_n) begin
      STICKY_RESET_N <= 1'b0;
    end else begin
      STICKY_RESET_N <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // processor bus reset: hold after hard release, processor-only pulse
  logic [CW-1:0] cpu_cnt;
  logic [CW-1:0] next_cpu_cnt;
  logic cpu_done;
  logic next_cpu_done;
  logic [CW-1:0] only_cnt;
  logic [CW-1:0] next_only_cnt;

  // hold timing and processor-only request
  always_comb begin
    next_cpu_cnt = cpu_cnt;
    next_cpu_done = cpu_done;
    next_only_cnt = only_cnt;
    if (hard_req) begin
      next_cpu_cnt = '0;
      next_cpu_done = 1'b0;
    end else if (!cpu_done) begin
      if (cpu_cnt == CPU_LAST) begin
        next_cpu_done = 1'b1;
      end else begin
        next_cpu_cnt = cpu_cnt + CW'(1);
      end
    end
    if (CFG_CPU_RESET_REQ && cpu_done && only_cnt == '0) begin
      next_only_cnt = CPU_LAST;
    end else if (only_cnt != '0) begin
      next_only_cnt = only_cnt - CW'(1);
    end
  end

  always_ff @(posedge CLK or negedge system_hard_reset_in_n_sync_n) begin
    if (!system_hard_reset_in_n_sync_n) begin
      cpu_cnt <= '0;
      cpu_done <= 1'b0;
      only_cnt <= '0;
    end else begin
      cpu_cnt <= next_cpu_cnt;
      cpu_done <= next_cpu_done;
      only_cnt <= next_only_cnt;
    end
  end

  always_ff @(posedge CLK or negedge system_hard_reset_in_n_sync_n) begin
    if (!system_hard_reset_in_n_sync_n) begin
      CPU_BUS_RESET_OUT_N <= '0;
    end else begin
      CPU_BUS_RESET_OUT_N <= {NUM_CPU_BUS{next_cpu_done &&
                                           next_only_cnt == '0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // root port links, one slice per port
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic next_port_n;
      logic next_train;

      always_comb begin
        next_port_n = next_hard_n & ~CFG_PORT_RESET[p];
        next_train = next_port_n & PCIE_PORT_RESET_N[p];
      end

      always_ff @(posedge CLK or negedge system_hard_reset_in_n_sync_n) begin
        if (!system_hard_reset_in_n_sync_n) begin
          PCIE_PORT_RESET_N[p] <= 1'b0;
          PCIE_TRAIN_EN[p] <= 1'b0;
        end else begin
          PCIE_PORT_RESET_N[p] <= next_port_n;
          PCIE_TRAIN_EN[p] <= next_train;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // bus re-init: drive on hang, clear queue on seen edge
  logic [2:0] drv_cnt;
  logic [2:0] next_drv_cnt;
  logic reinit_prev;
  logic next_oe;
  logic next_clear;

  always_comb begin
    next_drv_cnt = drv_cnt;
    if (INTERNAL_BUS_HANG && drv_cnt == 3'h0 &&
        state == srst_pkg::SRST_HARD_RUN) begin
      next_drv_cnt = DRV_LOAD;
    end else if (drv_cnt != 3'h0) begin
      next_drv_cnt = drv_cnt - 3'h1;
    end
    next_oe = (next_drv_cnt == 3'h0); // low while driving
    next_clear = reinit_prev & ~BUS_REINIT_N_IN;
  end

  always_ff @(posedge CLK or negedge system_hard_reset_in_n_sync_n) begin
    if (!system_hard_reset_in_n_sync_n) begin
      drv_cnt <= 3'h0;
      reinit_prev <= 1'b1;
      BUS_REINIT_N_OUT <= 1'b0;
      BUS_REINIT_N_OE <= 1'b1;
      IN_ORDER_QUEUE_CLEAR <= 1'b0;
    end else begin
      drv_cnt <= next_drv_cnt;
      reinit_prev <= BUS_REINIT_N_IN;
      BUS_REINIT_N_OUT <= 1'b0;
      BUS_REINIT_N_OE <= next_oe;
      IN_ORDER_QUEUE_CLEAR <= next_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active reset classes
  srst_pkg::srst_status_t next_status;

  always_comb begin
    next_status.power_good = 1'b0;
    next_status.hard = ~next_hard_n;
    next_status.cpu_only = (next_only_cnt != '0);
    next_status.targeted = |CFG_PORT_RESET;
    next_status.bus_reinit = ~BUS_REINIT_N_IN;
  end

  always_ff @(posedge CLK or negedge pg_rst_n) begin
    if (!pg_rst_n) begin
      RESET_STATUS <= srst_pkg::STATUS_RESET;
    end else begin
      RESET_STATUS <= next_status;
    end
  end

endmodule
`default_nettype wire

// *** srst_hub_model.sv ***
`default_nettype none
// companion hub: power-good source and hub reset driver
module srst_hub_model #(
  parameter int PG_DELAY = 16,
  parameter int HUB_HOLD = 12
) (
  input wire logic clk,
  input wire logic supply_ok,
  input wire logic hard_req,
  output logic power_good,
  output logic hub_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int pcnt = 0;
  int hcnt = 0;
  initial power_good = 1'b0;
  initial hub_reset_n = 1'b0;
  // supply tracking and hub reset hold
  always @(posedge clk) begin
    pcnt <= !supply_ok ? 0 : (pcnt < PG_DELAY ? pcnt + 1 : pcnt);
    power_good <= supply_ok && pcnt == PG_DELAY;
    hcnt <= (!power_good || hard_req) ? 0 :
      (hcnt < HUB_HOLD ? hcnt + 1 : hcnt);
    hub_reset_n <= power_good && !hard_req && hcnt == HUB_HOLD;
  end
endmodule
`default_nettype wire

// *** srst_checker_assertions.sv ***
`default_nettype none
// port-level checks of the reset root
module srst_checker #(
  parameter int NUM_CPU_BUS = srst_pkg::NUM_CPU_BUS_DEF,
  parameter int NUM_PORTS = srst_pkg::NUM_PORTS_DEF,
  parameter int CPU_HOLD_CYCLES = srst_pkg::CPU_HOLD_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PLATFORM_POWER_GOOD_IN,
  input wire logic SYSTEM_HARD_RESET_IN_N,
  input wire logic CFG_HARD_RESET_REQ,
  input wire logic CFG_CPU_RESET_REQ,
  input wire logic [NUM_PORTS-1:0] CFG_PORT_RESET,
  input wire logic BUS_REINIT_N_IN,
  input wire logic INTERNAL_BUS_HANG,
  input wire logic [NUM_CPU_BUS-1:0] CPU_BUS_RESET_OUT_N,
  input wire logic HARD_RESET_N,
  input wire logic CORE_RESET_N,
  input wire logic STICKY_RESET_N,
  input wire logic [NUM_PORTS-1:0] PCIE_PORT_RESET_N,
  input wire logic [NUM_PORTS-1:0] PCIE_TRAIN_EN,
  input wire logic BUS_REINIT_N_OE,
  input wire logic IN_ORDER_QUEUE_CLEAR
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic pg_ok = RESETN & PLATFORM_POWER_GOOD_IN;
  wire logic hard_ok = pg_ok & SYSTEM_HARD_RESET_IN_N;
  int unsigned hold;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // cycles since hard reset input released
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold <= 0;
    end else begin
      hold <= !hard_ok ? 0 : (hold > CPU_HOLD_CYCLES ? hold : hold + 1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_PG_SAFE: assert property (!PLATFORM_POWER_GOOD_IN |->
    !STICKY_RESET_N && !HARD_RESET_N && BUS_REINIT_N_OE && !PCIE_PORT_RESET_N)
    else $error("outputs not safe without power good");
  // sticky release needs three settled edges of power good
  AST_STICKY_UP: assert property (pg_ok && $past(pg_ok) &&
    $past(pg_ok, 2) && $past(pg_ok, 3) |-> STICKY_RESET_N)
    else $error("sticky reset outside power-good class");
  AST_HARD_IN: assert property (!SYSTEM_HARD_RESET_IN_N |->
    CPU_BUS_RESET_OUT_N == 0 && !HARD_RESET_N)
    else $error("hard reset input not obeyed");
  AST_RELEASE: assert property ($rose(hard_ok) |->
    !HARD_RESET_N [*4] ##[1:3] HARD_RESET_N)
    else $error("hard release outside window");
  AST_CORE_EQ: assert property (HARD_RESET_N == CORE_RESET_N)
    else $error("core and hard reset differ");
  AST_TRAIN: assert property (|PCIE_TRAIN_EN |->
    HARD_RESET_N && $past(HARD_RESET_N))
    else $error("training before hard release");
  AST_CPU_HOLD: assert property (
    $rose(CPU_BUS_RESET_OUT_N[0]) |-> hold >= CPU_HOLD_CYCLES)
    else $error("processor reset released early");
  AST_CPU_ONLY: assert property (CFG_CPU_RESET_REQ &&
    &CPU_BUS_RESET_OUT_N |=> CPU_BUS_RESET_OUT_N == 0 && HARD_RESET_N)
    else $error("processor-only reset wrong");
  // every requested port goes down, whichever it is
  AST_TARGET: assert property (|CFG_PORT_RESET |=>
    (PCIE_PORT_RESET_N & $past(CFG_PORT_RESET)) == '0 &&
    (PCIE_TRAIN_EN & $past(CFG_PORT_RESET)) == '0)
    else $error("targeted port not reset");
  // request is counted first, hard reset drops one edge later
  AST_CFG_HARD: assert property (CFG_HARD_RESET_REQ &&
    HARD_RESET_N |=> ##1 !HARD_RESET_N && PCIE_PORT_RESET_N == 0 &&
    STICKY_RESET_N) else $error("config hard reset wrong");
  AST_DRIVE: assert property (INTERNAL_BUS_HANG &&
    BUS_REINIT_N_OE && HARD_RESET_N |=>
    !BUS_REINIT_N_OE [*4] ##1 BUS_REINIT_N_OE)
    else $error("re-init drive length wrong");
  AST_QUEUE: assert property ($fell(BUS_REINIT_N_IN) |=>
    IN_ORDER_QUEUE_CLEAR ##1 !IN_ORDER_QUEUE_CLEAR)
    else $error("queue clear pulse wrong");
  // main scenarios reached
  cover property ($rose(HARD_RESET_N));
  cover property ($rose(CPU_BUS_RESET_OUT_N[0]));
  cover property (IN_ORDER_QUEUE_CLEAR);
  cover property (CFG_CPU_RESET_REQ && &CPU_BUS_RESET_OUT_N);
  cover property ($fell(HARD_RESET_N) && STICKY_RESET_N);
endmodule
bind srst_system_reset_controller srst_checker #(
  .NUM_CPU_BUS(NUM_CPU_BUS),
  .NUM_PORTS(NUM_PORTS),
  .CPU_HOLD_CYCLES(CPU_HOLD_CYCLES)
) u_chk (.*);
`default_nettype wire

// *** srst_system_reset_controller_tb.sv ***
`default_nettype none
// scenario bench for the reset root
module srst_system_reset_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic clk = 1'b0, resetn = 1'b0, sup = 1'b0, hreq = 1'b0;
  logic cfg_hard = 1'b0, cfg_cpu = 1'b0, hang = 1'b0;
  logic [3:0] port_rst = 4'h0;
  logic pg, hubn, hard, core, sticky, ri_out, ri_oe, in_order_queue;
  logic [1:0] cpu;
  logic [3:0] prst, train;
  srst_pkg::srst_status_t status;
  wire logic pin = ri_oe | ri_out; // pulled-up re-init wire
  int err_total = 0, tests_run = 0, cyc = 0, n;
  srst_hub_model hub (.clk(clk), .supply_ok(sup), .hard_req(hreq),
    .power_good(pg), .hub_reset_n(hubn));
  srst_system_reset_controller #(.CPU_HOLD_CYCLES(HOLD)) dut (
    .CLK(clk), .RESETN(resetn), .PLATFORM_POWER_GOOD_IN(pg),
    .SYSTEM_HARD_RESET_IN_N(hubn), .CFG_HARD_RESET_REQ(cfg_hard),
    .CFG_CPU_RESET_REQ(cfg_cpu), .CFG_PORT_RESET(port_rst),
    .BUS_REINIT_N_IN(pin), .INTERNAL_BUS_HANG(hang),
    .CPU_BUS_RESET_OUT_N(cpu), .HARD_RESET_N(hard), .CORE_RESET_N(core),
    .STICKY_RESET_N(sticky), .PCIE_PORT_RESET_N(prst),
    .PCIE_TRAIN_EN(train), .BUS_REINIT_N_OUT(ri_out),
    .BUS_REINIT_N_OE(ri_oe), .IN_ORDER_QUEUE_CLEAR(in_order_queue),
    .RESET_STATUS(status));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_up();
    while (hard !== 1'b1 || cpu !== 2'h3) begin
      @(posedge clk);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_on();
    @(posedge clk);
    sup <= 1'b1;
    #1;
    check({3'h0, status}, 8'h18);
    check({2'h0, sticky, ri_oe, prst}, 8'h10);
    while (pg !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1;
    check({4'h0, sticky, hard, cpu}, 8'h08);
    while (hubn !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    n = 0;
    while (hard !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h0, n >= 4 && n <= 6}, 8'h01);
    check({core, train}, 8'h10);
    @(posedge clk);
    #1;
    check({4'h0, train}, 8'h0f);
    while (cpu !== 2'h3) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h0, n >= HOLD}, 8'h01);
    check({3'h0, status}, 8'h00);
  endtask
  task automatic t_cpu_only();
    @(posedge clk);
    cfg_cpu <= 1'b1;
    @(posedge clk);
    cfg_cpu <= 1'b0;
    #1;
    check({4'h0, hard, core, cpu}, 8'h0c);
    check({7'h0, status.cpu_only}, 8'h01);
    wait_up();
  endtask
  task automatic t_targeted();
    @(posedge clk);
    port_rst <= 4'h2;
    @(posedge clk);
    #1;
    check({prst, train}, 8'hdd);
    check({7'h0, status.targeted}, 8'h01);
    @(posedge clk);
    port_rst <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
    check({prst, train}, 8'hff);
  endtask
  task automatic t_reinit();
    @(posedge clk);
    hang <= 1'b1;
    @(posedge clk);
    hang <= 1'b0;
    #1;
    check({6'h0, ri_oe, ri_out}, 8'h00);
    @(posedge clk);
    #1;
    check({3'h0, in_order_queue, prst}, 8'h1f);
    check({7'h0, status.bus_reinit}, 8'h01);
    @(posedge clk);
    #1;
    check({3'h0, in_order_queue, prst}, 8'h0f);
    repeat (2) @(posedge clk);
    #1;
    check({7'h0, ri_oe}, 8'h01);
  endtask
  // request is counted at one edge, hard reset drops at the next
  task automatic t_cfg_hard();
    @(posedge clk);
    cfg_hard <= 1'b1;
    @(posedge clk);
    cfg_hard <= 1'b0;
    @(posedge clk);
    #1;
    check({1'h0, hard, sticky, status.hard, prst}, 8'h30);
    wait_up();
  endtask
  task automatic t_hub_hard();
    @(posedge clk);
    hreq <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({hard, sticky, cpu, prst}, 8'h40);
    @(posedge clk);
    hreq <= 1'b0;
    wait_up();
  endtask
  task automatic t_pg_drop();
    @(posedge clk);
    sup <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({3'h0, status}, 8'h18);
    check({sticky, ri_oe, cpu, prst}, 8'h40);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    forever #4 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_power_on();
    t_cpu_only();
    t_targeted();
    t_reinit();
    t_cfg_hard();
    t_hub_hard();
    t_pg_drop();
    t_power_on();
    give_verdict();
  end
endmodule
`default_nettype wire
